// >>> core/tec_pkg.sv
// shared constants and types for the event/capture counter
package tec_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_PERIOD_NS = 25;
    localparam int TICK_MAX_NS = 409600; // slowest internal tick without the half option, code 000
    localparam int TICK_MIN_NS = 6400; // fastest internal tick, code 110
    localparam int TICK_MAX_CYC = TICK_MAX_NS / SYS_CLK_PERIOD_NS;
    localparam int TICK_MIN_CYC = TICK_MIN_NS / SYS_CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // encodings and reset values
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_EXT_PIN = 3'h7;
    localparam logic MODE_TIMER_EVENT = 1'b0;
    localparam logic MODE_CAPTURE = 1'b1;
    localparam logic [7:0] REG_A_RESET = 8'hff;
    localparam logic [7:0] REG_B_RESET = 8'hff;
    localparam logic [7:0] COUNT_ALL_ONES = 8'hff;
    localparam logic [7:0] COUNT_ZERO = 8'h00;

    // ------------------------------------------------------------
    // control word
    // ------------------------------------------------------------
    typedef struct packed {
        logic autoCaptureEnable;
        logic prescaleHalfSelect;
        logic [2:0] sourceClockSelect;
        logic modeSelect;
    } tec_ctrl_t;

    localparam tec_ctrl_t CTRL_RESET = '{1'b0, 1'b0, 3'h0, 1'b0};

endpackage : tec_pkg

// >>> core/tec_prescaler.sv
// internal tick generator with seven selectable taps
module tec_prescaler #(
    parameter int MAX_CYC = tec_pkg::TICK_MAX_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic [2:0] sourceClockSelect,
    input wire logic prescaleHalfSelect,
    output logic tick
);
    import tec_pkg::*;

    localparam logic [17:0] MAX_W = 18'(MAX_CYC);

    logic [17:0] divCount_r;
    logic [17:0] divCount_nxt;
    logic tick_r;
    logic tick_nxt;
    logic [17:0] lastCount;

    // period halves per code step, doubles with the half option
    always_comb begin
        lastCount = ((MAX_W >> sourceClockSelect) << prescaleHalfSelect) - 18'h00001;
        divCount_nxt = divCount_r;
        tick_nxt = 1'b0;
        if (!enable) begin
            divCount_nxt = 18'h00000;
        end else if (divCount_r >= lastCount) begin
            divCount_nxt = 18'h00000;
            tick_nxt = 1'b1;
        end else begin
            divCount_nxt = divCount_r + 18'h00001;
        end
    end

    // registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            divCount_r <= 18'h00000;
            tick_r <= 1'b0;
        end else begin
            divCount_r <= divCount_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

endmodule : tec_prescaler

// >>> core/tec_counter.sv
// 8-bit timer, event counter and pulse capture unit
module tec_counter #(
    parameter int TICK_MAX_CYC = tec_pkg::TICK_MAX_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic ctrlWrEn,
    input wire tec_pkg::tec_ctrl_t ctrlWrData,
    input wire logic runWrEn,
    input wire logic runWrData,
    input wire logic stopModeEntry,
    input wire logic regAWrEn,
    input wire logic [7:0] regAWrData,
    input wire logic regARdStrobe,
    input wire logic eventInputPin,
    output tec_pkg::tec_ctrl_t ctrlStatus,
    output logic runStatus,
    output logic [7:0] compareCaptureRegA,
    output logic [7:0] captureRegB,
    output logic [7:0] counterValue,
    output logic captureSuspended,
    output logic counterIrq
);
    import tec_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    tec_ctrl_t ctrl_r;
    tec_ctrl_t ctrl_nxt;
    logic run_r;
    logic run_nxt;
    logic pinMeta_r;
    logic pinSync_r;
    logic pinPrev_r;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic [7:0] regA_r;
    logic [7:0] regA_nxt;
    logic [7:0] regB_r;
    logic [7:0] regB_nxt;
    logic suspend_r;
    logic suspend_nxt;
    logic irq_r;
    logic irq_nxt;
    logic tick;
    logic pinRise;
    logic pinFall;
    logic extClock;
    logic [7:0] countInc;

    // ------------------------------------------------------------
    // control and run bit
    // ------------------------------------------------------------

    // control word and run bit updates
    always_comb begin
        ctrl_nxt = ctrl_r;
        run_nxt = run_r;
        if (ctrlWrEn) begin
            ctrl_nxt = ctrlWrData;
        end
        if (runWrEn) begin
            run_nxt = runWrData;
        end
        if (stopModeEntry) begin
            run_nxt = 1'b0;
        end
    end

    // control registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl_r <= CTRL_RESET;
            run_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            run_r <= run_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin synchroniser and edge detect
    // ------------------------------------------------------------

    // two-stage sync, third stage for edges
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pinMeta_r <= 1'b0;
            pinSync_r <= 1'b0;
            pinPrev_r <= 1'b0;
        end else begin
            pinMeta_r <= eventInputPin;
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
        end
    end

    assign pinRise = pinSync_r & ~pinPrev_r;
    assign pinFall = ~pinSync_r & pinPrev_r;

    // ------------------------------------------------------------
    // tick source
    // ------------------------------------------------------------
    assign extClock = (ctrl_r.sourceClockSelect == SRC_EXT_PIN);

    tec_prescaler #(
        .MAX_CYC(TICK_MAX_CYC)
    ) prescaler (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(run_r & ~extClock),
        .sourceClockSelect(ctrl_r.sourceClockSelect),
        .prescaleHalfSelect(ctrl_r.prescaleHalfSelect),
        .tick(tick)
    );

    assign countInc = count_r + 8'h01;

    // ------------------------------------------------------------
    // counter, compare and capture
    // ------------------------------------------------------------

    // next count, register A/B, suspension and interrupt
    always_comb begin
        count_nxt = count_r;
        regA_nxt = regA_r;
        regB_nxt = regB_r;
        suspend_nxt = suspend_r;
        irq_nxt = 1'b0;
        if (regARdStrobe) begin
            suspend_nxt = 1'b0;
        end
        if (regAWrEn) begin
            regA_nxt = regAWrData;
        end
        if (!run_r) begin
            count_nxt = COUNT_ZERO;
            suspend_nxt = 1'b0;
        end else if (ctrl_r.modeSelect == MODE_TIMER_EVENT) begin
            if (extClock) begin
                if (pinRise) begin
                    count_nxt = countInc;
                end
                if (pinFall && (count_r == regA_r)) begin
                    count_nxt = COUNT_ZERO;
                    irq_nxt = 1'b1;
                end
            end else if (tick) begin
                if (countInc == regA_r) begin
                    count_nxt = COUNT_ZERO;
                    irq_nxt = 1'b1;
                end else begin
                    count_nxt = countInc;
                end
            end
            if (ctrl_r.autoCaptureEnable && (count_r != COUNT_ZERO)) begin
                regB_nxt = count_r;
            end
        end else begin
            if (pinFall && !suspend_r) begin
                regB_nxt = count_r;
            end
            if (pinRise && !suspend_r) begin
                regA_nxt = count_r;
                irq_nxt = 1'b1;
                count_nxt = COUNT_ZERO;
            end else if (tick) begin
                if (count_r == COUNT_ALL_ONES) begin
                    count_nxt = COUNT_ZERO;
                    if (!suspend_r) begin
                        irq_nxt = 1'b1;
                        regA_nxt = COUNT_ALL_ONES;
                        suspend_nxt = 1'b1;
                    end
                end else begin
                    count_nxt = countInc;
                end
            end
        end
    end

    // counter registers
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count_r <= COUNT_ZERO;
            regA_r <= REG_A_RESET;
            regB_r <= REG_B_RESET;
            suspend_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            regA_r <= regA_nxt;
            regB_r <= regB_nxt;
            suspend_r <= suspend_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ctrlStatus = ctrl_r;
    assign runStatus = run_r;
    assign compareCaptureRegA = regA_r;
    assign captureRegB = regB_r;
    assign counterValue = count_r;
    assign captureSuspended = suspend_r;
    assign counterIrq = irq_r;

endmodule : tec_counter

// >>> verif/tec_counter_properties.sv
// port checker for the event/capture counter
module tec_counter_properties #(
    parameter int TICK_MAX_CYC = 16384
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic stopModeEntry,
    input wire logic regARdStrobe,
    input wire tec_pkg::tec_ctrl_t ctrlStatus,
    input wire logic runStatus,
    input wire logic [7:0] compareCaptureRegA,
    input wire logic [7:0] captureRegB,
    input wire logic [7:0] counterValue,
    input wire logic captureSuspended,
    input wire logic counterIrq
);
    timeunit 1ns;
    timeprecision 1ps;
    import tec_pkg::*;
    logic acapOn;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // auto-capture live in timer/event mode
    assign acapOn = runStatus && ctrlStatus.autoCaptureEnable && !ctrlStatus.modeSelect;
    a_stop_clears_run: assert property (stopModeEntry |=> !runStatus)
        else $error("run bit kept after stop entry");
    a_idle_count_zero: assert property (!runStatus && !$past(runStatus) |-> !counterValue)
        else $error("counter moves while stopped");
    a_irq_clears_count: assert property (counterIrq |-> counterValue == COUNT_ZERO)
        else $error("interrupt without counter clear");
    a_overflow_loads_ones: assert property ($rose(captureSuspended) |->
        counterIrq && compareCaptureRegA == COUNT_ALL_ONES) else $error("bad overflow");
    a_read_resumes: assert property (captureSuspended && regARdStrobe |=> !captureSuspended)
        else $error("read of A did not resume capture");
    a_no_irq_suspended: assert property (captureSuspended && $past(captureSuspended)
        && !$past(regARdStrobe) |-> !counterIrq) else $error("interrupt while suspended");
    a_b_frozen_suspended: assert property (captureSuspended && $past(captureSuspended)
        && !$past(regARdStrobe) |-> $stable(captureRegB)) else $error("capture while suspended");
    a_autocap_live: assert property (acapOn && $stable(ctrlStatus) && $past(runStatus)
        && $stable(counterValue) && counterValue != COUNT_ZERO |-> captureRegB == counterValue)
        else $error("auto-capture lags count");
    a_zero_skipped: assert property (acapOn && $stable(ctrlStatus) && $past(runStatus)
        && !counterValue && $past(counterValue) != COUNT_ZERO |-> captureRegB ==
        $past(counterValue)) else $error("zero copied into B");
    c_capture_irq: cover property (counterIrq && ctrlStatus.modeSelect);
    c_overflow: cover property ($rose(captureSuspended));
    c_event_irq: cover property (counterIrq && ctrlStatus.sourceClockSelect == SRC_EXT_PIN);
endmodule : tec_counter_properties

bind tec_counter tec_counter_properties #(.TICK_MAX_CYC(TICK_MAX_CYC)) u_props (.sys_clk,
    .srst, .stopModeEntry, .regARdStrobe, .ctrlStatus, .runStatus, .compareCaptureRegA,
    .captureRegB, .counterValue, .captureSuspended, .counterIrq);

// >>> verif/tec_pulse_source.sv
// behavioural pulse source on the event input pin
module tec_pulse_source #(
    parameter int MIN_HOLD = 3
) (
    input wire logic sys_clk,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // hold a level, never shorter than MIN_HOLD clock cycles
    task automatic level(input logic v, input int n);
        pin = v;
        repeat ((n < MIN_HOLD) ? MIN_HOLD : n) @(posedge sys_clk);
        #1;
    endtask : level
    initial pin = 1'b0;
endmodule : tec_pulse_source

// >>> verif/tb_top.sv
// self-checking bench for the event/capture counter
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import tec_pkg::*;
    logic sys_clk = 0, srst = 1, ctrlWrEn = 0, runWrEn = 0, runWrData = 0;
    logic stopModeEntry = 0, regAWrEn = 0, regARdStrobe = 0, eventInputPin;
    logic counterIrq, runStatus, captureSuspended;
    logic [7:0] regAWrData = 8'h00, compareCaptureRegA, captureRegB, counterValue;
    tec_ctrl_t ctrlWrData = CTRL_RESET;
    tec_ctrl_t ctrlStatus;
    int fail_count = 0, samples_checked = 0, irqs = 0, i0, n;
    // clock and interrupt tally
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (counterIrq === 1'b1) irqs <= irqs + 1;
    tec_counter #(.TICK_MAX_CYC(128)) uut (.sys_clk, .srst, .ctrlWrEn, .ctrlWrData, .runWrEn,
        .runWrData, .stopModeEntry, .regAWrEn, .regAWrData, .regARdStrobe, .eventInputPin,
        .ctrlStatus, .runStatus, .compareCaptureRegA, .captureRegB, .counterValue,
        .captureSuspended, .counterIrq);
    tec_pulse_source src (.sys_clk, .pin(eventInputPin));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : cyc
    // stop, write control word and A, then start
    task automatic setup(input tec_ctrl_t c, input logic [7:0] a);
        {ctrlWrEn, regAWrEn, runWrEn, runWrData} = 4'he;
        ctrlWrData = c;
        regAWrData = a;
        cyc(1);
        {ctrlWrEn, regAWrEn, runWrData} = 3'h1;
        cyc(1);
        runWrEn = 0;
    endtask : setup
    task automatic waitIrq(input int lim);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (counterIrq !== 1'b1 && n < lim);
        chk(8'(n < lim), 8'h01);
    endtask : waitIrq
    task automatic t_timer;
        for (int h = 0; h < 2; h++) begin
            for (int c = 0; c < 7; c++) begin
                setup('{1'b1, 1'(h), 3'(c), MODE_TIMER_EVENT}, 8'h03);
                waitIrq(1000);
                waitIrq(1000);
                chk(8'(n / (3 << h)), 8'(128 >> c));
                chk(captureRegB, 8'h02);
            end
        end
    endtask : t_timer
    task automatic t_event;
        setup('{1'b0, 1'b0, SRC_EXT_PIN, MODE_TIMER_EVENT}, 8'h02);
        src.level(1, 4);
        src.level(0, 4);
        i0 = irqs;
        src.level(1, 5);
        chk(counterValue, 8'h02);
        chk(8'(irqs - i0), 8'h00);
        src.level(0, 5);
        chk(8'(irqs - i0), 8'h01);
        src.level(1, 5);
        chk(counterValue, 8'h01);
        src.level(0, 5);
    endtask : t_event
    task automatic t_capture;
        srst = 1;
        cyc(2);
        srst = 0;
        setup('{1'b0, 1'b0, 3'h6, MODE_CAPTURE}, 8'h00);
        chk(8'(ctrlStatus), 8'h0d);
        i0 = irqs;
        src.level(0, 6);
        src.level(1, 10);
        chk(captureRegB, REG_B_RESET);
        src.level(0, 10);
        src.level(1, 4);
        chk(8'(captureRegB inside {[4:6]}), 8'h01);
        chk(8'(compareCaptureRegA inside {[9:11]}), 8'h01);
        chk(8'(irqs - i0), 8'h02);
        waitIrq(600);
        chk(compareCaptureRegA, COUNT_ALL_ONES);
        cyc(1); // tally takes the overflow pulse one edge late
        i0 = irqs;
        src.level(0, 6);
        src.level(1, 6);
        chk(8'(irqs - i0), 8'h00);
        regARdStrobe = 1;
        cyc(1);
        regARdStrobe = 0;
        cyc(1);
        chk(8'(captureSuspended), 8'h00);
        src.level(0, 6);
        src.level(1, 6);
        chk(8'(irqs - i0), 8'h01);
    endtask : t_capture
    task automatic t_stop;
        stopModeEntry = 1;
        cyc(1);
        stopModeEntry = 0;
        cyc(10);
        chk(8'(runStatus), 8'h00);
        chk(counterValue, COUNT_ZERO);
    endtask : t_stop
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // main sequence and watchdog
    initial begin
        cyc(6);
        srst = 0;
        t_timer;
        t_event;
        t_capture;
        t_stop;
        finish_test;
    end
    initial begin
        #1ms;
        fail_count++;
        finish_test;
    end
endmodule : tb_top
